// [hw/fcu_map.svh]
// Constants of the flash command and unlock controller.
// Assumes inclusion by bare name from the design files only.
//
// Notes on behaviour
// - Unlock needs first then second unlock byte
// - Unknown or misplaced command byte relocks, ignored while an operation runs
// - Command write-only, status read-only, one address
// - Page erase only as third command
// - Mass erase only as third command
// - Mass erase accepted from debug port only
// - Page erase hits only the active page
// - Protect-access byte selects sector lockout
// - Shared address reaches lockout only when selected
// - Status field reports unlock progress
// - Status top bits report running operation
// - Status read harmless, top two bits zero
// - Page field gives address bits fifteen to nine
// - Bit seven maps information area high
// - Lockout bits reset clear, user only sets
// - Debug accesses ignore write-protect option
// - Debug ignores lockout and page limit
// - Debug may set or clear lockout bits
// - Debug skips page confirm, writes page unlocked
// - One open page, relock before another
// - User code walled off from reserved region
// - Page confirm mismatch relocks, match activates
// - Locked-out sector refuses program and erase
// - Finished erase returns to locked
`ifndef FCU_MAP_SVH
`define FCU_MAP_SVH

// Register file addresses
`define FCU_ADDR_CMD 12'hff8
`define FCU_ADDR_PAGE 12'hff9

// Command bytes
`define FCU_CMD_UNLOCK1 8'h73
`define FCU_CMD_UNLOCK2 8'h8c
`define FCU_CMD_PAGE_ERASE 8'h95
`define FCU_CMD_MASS_ERASE 8'h63
`define FCU_CMD_PROT_SEL 8'h5e

// Status field codes, six bits
`define FCU_ST_LOCKED 6'h00
`define FCU_ST_FIRST 6'h01
`define FCU_ST_SECOND 6'h02
`define FCU_ST_UNLOCKED 6'h03
`define FCU_ST_PROT 6'h04
`define FCU_ST_PROGRAM 6'h08
`define FCU_ST_PAGE_ERASE 6'h10
`define FCU_ST_MASS_ERASE 6'h20

// Field positions and reset values
`define FCU_BYTE_RESET 8'h00
`define FCU_INFO_BIT 7
`define FCU_PAGE_MSB 6
`define FCU_ADDR_PAGE_MSB 15
`define FCU_ADDR_PAGE_LSB 9
`define FCU_SECTOR_MSB 12
`define FCU_SECTOR_LSB 10

// Address windows
`define FCU_USER_TOP 16'h2000
`define FCU_RESV_TOP 16'h3000
`define FCU_INFO_LO 16'hfe00

`endif

// [hw/fcu_pkg.sv]
// Types shared by the flash command and unlock controller.
// Assumes nothing of its surroundings.
package fcu_pkg;

  // Controller sequence states
  typedef enum logic [2:0] {
    FCU_LOCKED,
    FCU_FIRST,
    FCU_SECOND,
    FCU_UNLOCKED,
    FCU_PROT_SEL,
    FCU_PROGRAM,
    FCU_PAGE_ERASE,
    FCU_MASS_ERASE
  } fcu_state_e;

  typedef logic [7:0] fcu_byte_t;

endpackage

// [hw/fcu_status_enc.sv]
// Status byte encoder of the flash controller.
// Assumes the state comes from the controller's own register.
`timescale 1ns/10ps
`default_nettype none
`include "fcu_map.svh"

module fcu_status_enc
  import fcu_pkg::*;
(
  input wire fcu_state_e state_i,
  output logic [7:0] status_o
);

  // Reserved top bits stay zero; low bits of busy codes read zero
  always_comb begin
    status_o = `FCU_BYTE_RESET;
    case (state_i)
      FCU_LOCKED: status_o[5:0] = `FCU_ST_LOCKED;
      FCU_FIRST: status_o[5:0] = `FCU_ST_FIRST;
      FCU_SECOND: status_o[5:0] = `FCU_ST_SECOND;
      FCU_UNLOCKED: status_o[5:0] = `FCU_ST_UNLOCKED;
      FCU_PROT_SEL: status_o[5:0] = `FCU_ST_PROT;
      FCU_PROGRAM: status_o[5:0] = `FCU_ST_PROGRAM;
      FCU_PAGE_ERASE: status_o[5:0] = `FCU_ST_PAGE_ERASE;
      FCU_MASS_ERASE: status_o[5:0] = `FCU_ST_MASS_ERASE;
      default: status_o[5:0] = `FCU_ST_LOCKED;
    endcase
  end

endmodule
`default_nettype wire

// [hw/fcu_region_guard.sv]
// Address guard for memory accesses into the flash.
// Assumes the caller qualifies the result with its request strobe.
`timescale 1ns/10ps
`default_nettype none
`include "fcu_map.svh"

module fcu_region_guard (
  input wire logic [15:0] addr_i,
  input wire logic exec_resv_i,
  input wire logic info_area_select_i,
  output logic blocked_o,
  output logic info_hit_o
);

  // Only code running inside the reserved region may touch it
  always_comb begin
    blocked_o = (addr_i >= `FCU_USER_TOP) && (addr_i < `FCU_RESV_TOP)
      && !exec_resv_i;
    info_hit_o = info_area_select_i && (addr_i >= `FCU_INFO_LO);
  end

endmodule
`default_nettype wire

// [hw/fcu_top.sv]
// Flash command, unlock and protection controller.
// Assumes single-cycle register strobes, one access per cycle,
// and a done pulse from the flash array after each operation.
`timescale 1ns/10ps
`default_nettype none
`include "fcu_map.svh"

module fcu_top
  import fcu_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic debug_access_i,
  input wire logic mem_req_i,
  input wire logic mem_wr_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic exec_resv_i,
  input wire logic wp_option_i,
  input wire logic flash_done_i,
  output logic [7:0] reg_rdata_o,
  output logic mem_grant_o,
  output logic mem_block_o,
  output logic mem_info_o,
  output logic info_sel_o,
  output logic prog_start_o,
  output logic [15:0] prog_addr_o,
  output logic page_erase_o,
  output logic mass_erase_o,
  output logic [6:0] erase_page_o,
  output logic [7:0] sector_lock_o
);

  ////////////////////////////////////////////////////////////////////
  // Declarations

  fcu_state_e state_reg, state_next;
  fcu_byte_t page_reg, page_next;
  fcu_byte_t lock_reg, lock_next;
  fcu_byte_t rdata_reg, rdata_next;
  logic grant_reg, grant_next;
  logic block_reg, block_next;
  logic minfo_reg, minfo_next;
  logic prog_reg, prog_next;
  logic [15:0] paddr_reg, paddr_next;
  logic perase_reg, perase_next;
  logic merase_reg, merase_next;
  logic [7:0] status_w;
  logic blocked_w;
  logic info_hit_w;
  logic cmd_wr;
  logic page_wr;
  logic page_ok;
  logic prog_ok;
  logic erase_ok;

  // Sector number of a flash byte address
  function automatic logic [2:0] sector_of(input logic [15:0] a);
    sector_of = a[`FCU_SECTOR_MSB:`FCU_SECTOR_LSB];
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Helpers

  fcu_status_enc u_status (
    .state_i(state_reg),
    .status_o(status_w)
  );

  fcu_region_guard u_guard (
    .addr_i(mem_addr_i),
    .exec_resv_i(exec_resv_i),
    .info_area_select_i(page_reg[`FCU_INFO_BIT]),
    .blocked_o(blocked_w),
    .info_hit_o(info_hit_w)
  );

  // Address decode; writes to the command address never read back
  assign cmd_wr = reg_wr_i && (reg_addr_i == `FCU_ADDR_CMD);
  assign page_wr = reg_wr_i && (reg_addr_i == `FCU_ADDR_PAGE);

  // Program permission; debug drops page, sector and option checks
  assign page_ok = mem_addr_i[`FCU_ADDR_PAGE_MSB:`FCU_ADDR_PAGE_LSB]
    == page_reg[`FCU_PAGE_MSB:0];
  assign prog_ok = debug_access_i
    || (!wp_option_i && page_ok && !lock_reg[sector_of(mem_addr_i)]);
  // Erase permission, active page's sector checked for user code
  assign erase_ok = debug_access_i
    || (!wp_option_i
        && !lock_reg[sector_of({page_reg[`FCU_PAGE_MSB:0], 9'h000})]);

  ////////////////////////////////////////////////////////////////////
  // Next-state logic

  // Erase or program done first, then register writes, then memory accesses
  always_comb begin
    state_next = state_reg;
    page_next = page_reg;
    lock_next = lock_reg;
    rdata_next = rdata_reg;
    grant_next = 1'b0;
    block_next = 1'b0;
    minfo_next = minfo_reg;
    prog_next = 1'b0;
    paddr_next = paddr_reg;
    perase_next = 1'b0;
    merase_next = 1'b0;
    // Status reads change nothing but the read latch
    if (reg_rd_i) begin
      if (reg_addr_i == `FCU_ADDR_CMD) begin
        rdata_next = status_w;
      end else if (reg_addr_i == `FCU_ADDR_PAGE) begin
        rdata_next = (state_reg == FCU_PROT_SEL) ? lock_reg : page_reg;
      end else begin
        rdata_next = `FCU_BYTE_RESET;
      end
    end
    if ((state_reg == FCU_PAGE_ERASE || state_reg == FCU_MASS_ERASE)
        && flash_done_i) begin
      state_next = FCU_LOCKED;
    end else if (state_reg == FCU_PROGRAM && flash_done_i) begin
      state_next = FCU_UNLOCKED;
    end else if (cmd_wr) begin
      case (state_reg)
        FCU_LOCKED, FCU_PROT_SEL: begin
          if (reg_wdata_i == `FCU_CMD_UNLOCK1) begin
            state_next = FCU_FIRST;
          end else if (reg_wdata_i == `FCU_CMD_PROT_SEL) begin
            state_next = FCU_PROT_SEL;
          end else begin
            state_next = FCU_LOCKED;
          end
        end
        FCU_FIRST: begin
          if (reg_wdata_i != `FCU_CMD_UNLOCK2) begin
            state_next = FCU_LOCKED;
          end else if (debug_access_i) begin
            state_next = FCU_UNLOCKED;
          end else begin
            state_next = FCU_SECOND;
          end
        end
        FCU_UNLOCKED: begin
          // Third command; anything else closes the open page
          state_next = FCU_LOCKED;
          if (reg_wdata_i == `FCU_CMD_PAGE_ERASE && erase_ok) begin
            state_next = FCU_PAGE_ERASE;
            perase_next = 1'b1;
          end else if (reg_wdata_i == `FCU_CMD_MASS_ERASE
                       && debug_access_i) begin
            state_next = FCU_MASS_ERASE;
            merase_next = 1'b1;
          end
        end
        FCU_SECOND: state_next = FCU_LOCKED;
        default: state_next = state_reg;
      endcase
    end else if (page_wr) begin
      case (state_reg)
        FCU_PROT_SEL: begin
          if (debug_access_i) begin
            lock_next = reg_wdata_i;
          end else begin
            lock_next = lock_reg | reg_wdata_i;
          end
        end
        FCU_LOCKED: page_next = reg_wdata_i;
        FCU_SECOND: begin
          if (reg_wdata_i == page_reg) begin
            state_next = FCU_UNLOCKED;
          end else begin
            state_next = FCU_LOCKED;
          end
        end
        FCU_UNLOCKED: begin
          if (debug_access_i) begin
            page_next = reg_wdata_i;
          end
        end
        default: page_next = page_reg;
      endcase
    end else if (mem_req_i) begin
      minfo_next = info_hit_w;
      if (blocked_w) begin
        block_next = 1'b1;
      end else if (!mem_wr_i) begin
        grant_next = 1'b1;
      end else if (state_reg == FCU_UNLOCKED && prog_ok) begin
        grant_next = 1'b1;
        prog_next = 1'b1;
        paddr_next = mem_addr_i;
        state_next = FCU_PROGRAM;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State registers; clock enable low freezes everything except reset

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= FCU_LOCKED;
      page_reg <= `FCU_BYTE_RESET;
      lock_reg <= `FCU_BYTE_RESET;
      rdata_reg <= `FCU_BYTE_RESET;
      grant_reg <= 1'b0;
      block_reg <= 1'b0;
      minfo_reg <= 1'b0;
      prog_reg <= 1'b0;
      paddr_reg <= 16'h0000;
      perase_reg <= 1'b0;
      merase_reg <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      page_reg <= page_next;
      lock_reg <= lock_next;
      rdata_reg <= rdata_next;
      grant_reg <= grant_next;
      block_reg <= block_next;
      minfo_reg <= minfo_next;
      prog_reg <= prog_next;
      paddr_reg <= paddr_next;
      perase_reg <= perase_next;
      merase_reg <= merase_next;
    end
  end

  // Outputs straight from flops
  assign reg_rdata_o = rdata_reg;
  assign mem_grant_o = grant_reg;
  assign mem_block_o = block_reg;
  assign mem_info_o = minfo_reg;
  assign info_sel_o = page_reg[`FCU_INFO_BIT];
  assign prog_start_o = prog_reg;
  assign prog_addr_o = paddr_reg;
  assign page_erase_o = perase_reg;
  assign mass_erase_o = merase_reg;
  assign erase_page_o = page_reg[`FCU_PAGE_MSB:0];
  assign sector_lock_o = lock_reg;

  ////////////////////////////////////////////////////////////////////
  // Assertions and covers

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  unlock_first_a: assert property (
    ce_i && cmd_wr && state_reg == FCU_LOCKED
      && reg_wdata_i == `FCU_CMD_UNLOCK1 |=> state_reg == FCU_FIRST)
    else $error("first unlock byte not taken");

  unlock_path_a: assert property (
    state_reg == FCU_UNLOCKED && $past(state_reg) != FCU_UNLOCKED
      |-> $past(state_reg) == FCU_SECOND || $past(state_reg) == FCU_PROGRAM
        || ($past(state_reg) == FCU_FIRST && $past(debug_access_i)))
    else $error("unlocked without full sequence");

  bad_cmd_a: assert property (
    ce_i && cmd_wr && state_reg == FCU_FIRST
      && reg_wdata_i != `FCU_CMD_UNLOCK2 |=> state_reg == FCU_LOCKED)
    else $error("bad command did not relock");

  status_read_a: assert property (
    ce_i && reg_rd_i && reg_addr_i == `FCU_ADDR_CMD
      |=> reg_rdata_o == $past(status_w) && reg_rdata_o[7:6] == 2'h0
        && ($past(reg_wr_i) || $past(mem_req_i) || $past(flash_done_i)
            || state_reg == $past(state_reg)))
    else $error("status read wrong");

  user_mass_a: assert property (
    ce_i && cmd_wr && !debug_access_i |=> !mass_erase_o)
    else $error("user mass erase accepted");

  erase_page_a: assert property (
    $rose(page_erase_o) |-> $past(state_reg) == FCU_UNLOCKED
      && state_reg == FCU_PAGE_ERASE && erase_page_o == $past(erase_page_o))
    else $error("page erase out of sequence");

  set_only_a: assert property (
    ce_i && page_wr && state_reg == FCU_PROT_SEL && !debug_access_i
      |=> sector_lock_o == ($past(sector_lock_o) | $past(reg_wdata_i)))
    else $error("user cleared lockout bit");

  debug_clear_a: assert property (
    ce_i && page_wr && state_reg == FCU_PROT_SEL && debug_access_i
      |=> sector_lock_o == $past(reg_wdata_i))
    else $error("debug lockout write lost");

  erase_done_a: assert property (
    ce_i && state_reg == FCU_PAGE_ERASE && flash_done_i
      |=> state_reg == FCU_LOCKED ##0 status_w == `FCU_BYTE_RESET)
    else $error("erase did not relock");

  resv_block_a: assert property (
    ce_i && mem_req_i && !reg_wr_i && blocked_w
      |=> mem_block_o && !mem_grant_o && !prog_start_o)
    else $error("reserved region reached");

  prog_guard_a: assert property (
    $rose(prog_start_o) |-> $past(debug_access_i)
      || (!sector_lock_o[sector_of(prog_addr_o)]
          && prog_addr_o[`FCU_ADDR_PAGE_MSB:`FCU_ADDR_PAGE_LSB] == erase_page_o))
    else $error("program outside allowed page");

  confirm_c: cover property (
    state_reg == FCU_SECOND ##1 state_reg == FCU_UNLOCKED);
  page_erase_c: cover property (page_erase_o ##[1:20] state_reg == FCU_LOCKED);
  mass_erase_c: cover property (mass_erase_o);
  prot_write_c: cover property (
    state_reg == FCU_PROT_SEL && page_wr && ce_i);

endmodule
`default_nettype wire

// [verif/fcu_flash_model.sv]
// Flash array stand-in: answers each start pulse not overtaken by another with a done pulse.
// Assumes start pulses come from the controller on the shared clock.
`timescale 1ns/10ps
`default_nettype none
module fcu_flash_model #(
  parameter int DELAY = 8
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic start_i,
  output logic done_o
);
  int cnt;
  // Busy span, then one done pulse; a new start restarts the span
  always @(posedge clock_i) begin
    if (rst_i) begin
      cnt <= 0;
      done_o <= 1'b0;
    end else begin
      done_o <= (cnt == 1);
      if (start_i) begin
        cnt <= DELAY;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

// [verif/fcu_top_tb_top.sv]
// Self-checking bench for the flash command and unlock controller.
// Assumes the flash model answers each start after DELAY cycles.
`timescale 1ns/10ps
`default_nettype none
module fcu_top_tb_top;
  localparam int DELAY = 8;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [11:0] reg_addr_i = 12'h000;
  logic [7:0] reg_wdata_i = 8'h00;
  logic debug_access_i = 1'b0;
  logic mem_req_i = 1'b0;
  logic mem_wr_i = 1'b0;
  logic [15:0] mem_addr_i = 16'h0000;
  logic exec_resv_i = 1'b0;
  logic wp_option_i = 1'b0;
  logic flash_done_i;
  logic [7:0] reg_rdata_o, sector_lock_o;
  logic mem_grant_o, mem_block_o, mem_info_o, info_sel_o, prog_start_o;
  logic page_erase_o, mass_erase_o;
  logic [15:0] prog_addr_o;
  logic [6:0] erase_page_o;
  int fails = 0;
  int comparisons = 0;

  ////////////////////////////////////////////////////////////////////
  // Clock, design and flash stand-in
  always #4 clock_i = ~clock_i;
  fcu_top dut (.clock_i, .rst_i, .ce_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .debug_access_i, .mem_req_i, .mem_wr_i, .mem_addr_i,
    .exec_resv_i, .wp_option_i, .flash_done_i, .reg_rdata_o, .mem_grant_o,
    .mem_block_o, .mem_info_o, .info_sel_o, .prog_start_o, .prog_addr_o,
    .page_erase_o, .mass_erase_o, .erase_page_o, .sector_lock_o);
  fcu_flash_model #(.DELAY(DELAY)) flash (.clock_i, .rst_i,
    .start_i(prog_start_o | page_erase_o | mass_erase_o), .done_o(flash_done_i));

  ////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One write strobe, released on the edge that takes it
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic dg);
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    debug_access_i <= dg;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  // Read data lands on the taking edge itself
  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(what, reg_rdata_o, exp);
  endtask

  // Memory access; grant and block stand one cycle only
  task automatic mem(input logic [15:0] a, input logic w, dg, rs, eg, eb);
    @(posedge clock_i);
    mem_req_i <= 1'b1;
    mem_addr_i <= a;
    mem_wr_i <= w;
    debug_access_i <= dg;
    exec_resv_i <= rs;
    @(posedge clock_i);
    mem_req_i <= 1'b0;
    #1;
    chk("grant", mem_grant_o, eg);
    chk("block", mem_block_o, eb);
  endtask

  task automatic ul(input logic [7:0] pg);
    wr(12'hff9, pg, 1'b0);
    wr(12'hff8, 8'h73, 1'b0);
    wr(12'hff8, 8'h8c, 1'b0);
    wr(12'hff9, pg, 1'b0);
  endtask

  task automatic settle;
    repeat (DELAY + 4) @(posedge clock_i);
  endtask

  ////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    rd(12'hff8, 8'h00, "status at reset");
    rd(12'h000, 8'h00, "unmapped read");
    chk("lockout at reset", sector_lock_o, 8'h00);
  endtask

  // Clock enable low freezes the controller, so the byte is lost
  task automatic t_hold;
    @(posedge clock_i);
    ce_i <= 1'b0;
    wr(12'hff8, 8'h73, 1'b0);
    @(posedge clock_i);
    ce_i <= 1'b1;
    rd(12'hff8, 8'h00, "frozen by enable");
  endtask

  // Mid-run reset clears lockout and page selector
  task automatic t_rerun;
    wr(12'hff8, 8'h5e, 1'b0);
    wr(12'hff9, 8'h81, 1'b0);
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    #1;
    chk("lockout after reset", sector_lock_o, 8'h00);
    chk("info after reset", info_sel_o, 1'b0);
    rd(12'hff8, 8'h00, "status after reset");
  endtask

  task automatic t_erase;
    wr(12'hff9, 8'h05, 1'b0);
    wr(12'hff8, 8'h73, 1'b0);
    rd(12'hff8, 8'h01, "first byte");
    rd(12'hff8, 8'h01, "status reread");
    wr(12'hff8, 8'h8c, 1'b0);
    rd(12'hff8, 8'h02, "second byte");
    wr(12'hff9, 8'h05, 1'b0);
    rd(12'hff8, 8'h03, "unlocked");
    wr(12'hff8, 8'h95, 1'b0);
    chk("page erase", {page_erase_o, erase_page_o}, 8'h85);
    rd(12'hff8, 8'h10, "erase busy");
    settle();
    rd(12'hff8, 8'h00, "relock after erase");
  endtask

  task automatic t_bad;
    wr(12'hff8, 8'h73, 1'b0);
    wr(12'hff8, 8'h95, 1'b0);
    chk("early erase", page_erase_o, 1'b0);
    rd(12'hff8, 8'h00, "out of order");
    wr(12'hff9, 8'h05, 1'b0);
    wr(12'hff8, 8'h73, 1'b0);
    wr(12'hff8, 8'h8c, 1'b0);
    wr(12'hff9, 8'h06, 1'b0);
    rd(12'hff8, 8'h00, "page mismatch");
  endtask

  task automatic t_mass;
    ul(8'h05);
    wr(12'hff8, 8'h63, 1'b0);
    chk("user mass erase", mass_erase_o, 1'b0);
    wr(12'hff8, 8'h73, 1'b1);
    wr(12'hff8, 8'h8c, 1'b1);
    rd(12'hff8, 8'h03, "debug unlock");
    wr(12'hff9, 8'h07, 1'b1);
    chk("debug page write", erase_page_o, 7'h07);
    wr(12'hff8, 8'h63, 1'b1);
    chk("debug mass erase", mass_erase_o, 1'b1);
    rd(12'hff8, 8'h20, "mass busy");
    settle();
    rd(12'hff8, 8'h00, "relock after mass");
  endtask

  task automatic t_prog;
    ul(8'h05);
    mem(16'h0a10, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    chk("program start", {prog_start_o, prog_addr_o}, 24'h01_0a10);
    rd(12'hff8, 8'h08, "program busy");
    settle();
    mem(16'h0c00, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    @(posedge clock_i);
    wp_option_i <= 1'b1;
    mem(16'h0a10, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    mem(16'h0c00, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    settle();
    @(posedge clock_i);
    wp_option_i <= 1'b0;
    wr(12'hff8, 8'h00, 1'b0);
  endtask

  task automatic t_lock;
    wr(12'hff8, 8'h5e, 1'b0);
    rd(12'hff8, 8'h04, "lockout selected");
    wr(12'hff9, 8'h04, 1'b0);
    chk("lockout set", sector_lock_o, 8'h04);
    wr(12'hff9, 8'h01, 1'b0);
    chk("lockout set only", sector_lock_o, 8'h05);
    wr(12'hff8, 8'h00, 1'b0);
    ul(8'h05);
    chk("page after lockout", erase_page_o, 7'h05);
    mem(16'h0a10, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    wr(12'hff8, 8'h95, 1'b0);
    chk("locked sector erase", page_erase_o, 1'b0);
    wr(12'hff8, 8'h00, 1'b1);
    wr(12'hff8, 8'h5e, 1'b1);
    wr(12'hff9, 8'h00, 1'b1);
    chk("debug clears lockout", sector_lock_o, 8'h00);
    wr(12'hff8, 8'h00, 1'b0);
  endtask

  task automatic t_mem;
    mem(16'h2100, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    mem(16'h2100, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    wr(12'hff9, 8'h80, 1'b0);
    chk("info select", info_sel_o, 1'b1);
    mem(16'hfe00, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    chk("info hit", mem_info_o, 1'b1);
    mem(16'hfd00, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    chk("info miss", mem_info_o, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////
  // Verdict, main sequence and watchdog
  task automatic close_out;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset();
    t_hold();
    t_erase();
    t_bad();
    t_mass();
    t_prog();
    t_lock();
    t_mem();
    t_rerun();
    close_out();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #100000;
    fails++;
    close_out();
  end
endmodule
`default_nettype wire
